/* File: rtl/gpx_ctrl.sv */
// controller end: register port, two-wire bit engine, write and read sequences
`timescale 1ns/10ps
module gpx_ctrl
  import gpx_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  gpx_if.ctrl             bus,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata
);

  logic [6:0] tgt_r;
  logic [7:0] cmd_r;
  logic [7:0] wdata_r;
  logic [7:0] rdata_r;
  logic       op_r;
  logic       busy_r;
  logic       nack_r;
  logic       abort_r;
  logic [2:0] step_r;
  logic [1:0] phase_r;
  logic [3:0] bitn_r;
  logic [7:0] rxsh_r;
  logic [7:0] qcnt_r;
  logic       scl_oe_r;
  logic       sda_oe_r;
  logic       sda_s1_r;
  logic       sda_s2_r;
  logic       int_s1_r;
  logic       int_s2_r;
  logic       tick;
  gpx_act_t   act;
  logic [7:0] txb;

  // write: start, addr w, code, data, stop; read puts restart, addr r, byte in place of data
  function automatic gpx_act_t step_act(input logic op, input logic [2:0] s);
    case (s)
      3'h0:    step_act = A_START;
      3'h3:    step_act = op ? A_START : A_TX;
      3'h4:    step_act = op ? A_TX : A_STOP;
      3'h5:    step_act = A_RX;
      3'h6:    step_act = A_STOP;
      default: step_act = A_TX;
    endcase
  endfunction : step_act

  function automatic logic [7:0] tx_byte(input logic [2:0] s, input logic [6:0] t,
                                         input logic [7:0] c, input logic [7:0] d);
    case (s)
      3'h1:    tx_byte = {t, 1'b0};
      3'h2:    tx_byte = c;
      3'h4:    tx_byte = {t, 1'b1};
      default: tx_byte = d;
    endcase
  endfunction : tx_byte

  assign act  = abort_r ? A_STOP : step_act(op_r, step_r);
  assign txb  = tx_byte(step_r, tgt_r, cmd_r, wdata_r);
  assign tick = qcnt_r == 8'(QTR_CYC - 1);

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      int_s1_r <= 1'b1;
      int_s2_r <= 1'b1;
    end
    else
    begin
      sda_s1_r <= bus.sda;
      sda_s2_r <= sda_s1_r;
      int_s1_r <= bus.int_n;
      int_s2_r <= int_s1_r;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      qcnt_r <= 8'h00;
    else if (!busy_r || tick)
      qcnt_r <= 8'h00;
    else
      qcnt_r <= qcnt_r + 8'h01;
  end

  // settings are frozen while a sequence runs
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tgt_r   <= RST_TARGET;
      cmd_r   <= 8'h00;
      wdata_r <= 8'h00;
    end
    else if (reg_wr && !busy_r)
    begin
      if (reg_addr == CR_TARGET)
        tgt_r <= reg_wdata[6:0];
      else if (reg_addr == CR_CMD)
        cmd_r <= reg_wdata;
      else if (reg_addr == CR_WDATA)
        wdata_r <= reg_wdata;
    end
  end

  // each bit is four quarters: set data, raise clock, sample, drop clock
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      op_r     <= 1'b0;
      busy_r   <= 1'b0;
      nack_r   <= 1'b0;
      abort_r  <= 1'b0;
      step_r   <= 3'h0;
      phase_r  <= 2'h0;
      bitn_r   <= 4'h0;
      rxsh_r   <= 8'h00;
      rdata_r  <= 8'h00;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end
    else if (!busy_r)
    begin
      if (reg_wr && reg_addr == CR_GO)
      begin
        op_r    <= reg_wdata[0];
        busy_r  <= 1'b1;
        nack_r  <= 1'b0;
        abort_r <= 1'b0;
        step_r  <= 3'h0;
        phase_r <= 2'h0;
        bitn_r  <= 4'h0;
      end
    end
    else if (tick)
    begin
      phase_r <= phase_r + 2'h1;
      case (act)
        A_START:
          case (phase_r)
            2'h0: sda_oe_r <= 1'b0;
            2'h1: scl_oe_r <= 1'b0;
            2'h2: sda_oe_r <= 1'b1;
            default:
            begin
              scl_oe_r <= 1'b1;
              step_r   <= step_r + 3'h1;
            end
          endcase
        A_STOP:
          case (phase_r)
            2'h0: sda_oe_r <= 1'b1;
            2'h1: scl_oe_r <= 1'b0;
            2'h2: sda_oe_r <= 1'b0;
            default: busy_r <= 1'b0;
          endcase
        default:
          case (phase_r)
            2'h0: sda_oe_r <= (act == A_TX && bitn_r < BIT_ACK) ? !txb[3'(4'h7 - bitn_r)] : 1'b0;
            2'h1: scl_oe_r <= 1'b0;
            2'h2:
            begin
              if (act == A_TX && bitn_r == BIT_ACK && sda_s2_r)
                nack_r <= 1'b1;
              if (act == A_RX && bitn_r < BIT_ACK)
                rxsh_r <= {rxsh_r[6:0], sda_s2_r};
            end
            default:
            begin
              scl_oe_r <= 1'b1;
              if (bitn_r == BIT_ACK)
              begin
                bitn_r <= 4'h0;
                step_r <= step_r + 3'h1;
                // stop takes over only after the ack clock has fallen
                abort_r <= nack_r;
                if (act == A_RX)
                  rdata_r <= rxsh_r;
              end
              else
                bitn_r <= bitn_r + 4'h1;
            end
          endcase
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      reg_rdata <= 8'h00;
    else if (!reg_rd)
      reg_rdata <= 8'h00;
    else if (reg_addr == CR_TARGET)
      reg_rdata <= {1'b0, tgt_r};
    else if (reg_addr == CR_CMD)
      reg_rdata <= cmd_r;
    else if (reg_addr == CR_WDATA)
      reg_rdata <= wdata_r;
    else if (reg_addr == CR_STATUS)
      reg_rdata <= {5'h00, !int_s2_r, nack_r, busy_r};
    else if (reg_addr == CR_RDATA)
      reg_rdata <= rdata_r;
    else
      reg_rdata <= 8'h00;
  end

  assign bus.scl_o    = 1'b0;
  assign bus.scl_oe   = scl_oe_r;
  assign bus.c_sda_o  = 1'b0;
  assign bus.c_sda_oe = sda_oe_r;

endmodule : gpx_ctrl

/* File: include/gpx_pkg.sv */
// shared constants and types for the i2c gpio expander pair
package gpx_pkg;
  localparam int CLK_NS        = 10;
  localparam int SCL_PERIOD_NS = 1000;
  localparam int QTR_RAW       = SCL_PERIOD_NS / (4 * CLK_NS);
  localparam int QTR_CYC       = (QTR_RAW < 1) ? 1 : QTR_RAW;
  localparam logic [1:0] REG_PIN_LEVEL = 2'h0;
  localparam logic [1:0] REG_OUT_LATCH = 2'h1;
  localparam logic [1:0] REG_INV_MASK  = 2'h2;
  localparam logic [1:0] REG_PIN_DIR   = 2'h3;
  localparam logic [7:0] RST_OUT_LATCH = 8'hFF;
  localparam logic [7:0] RST_INV_MASK  = 8'h00;
  localparam logic [7:0] RST_PIN_DIR   = 8'hFF;
  localparam logic [1:0] RST_SEL       = 2'h0;
  localparam logic [3:0] ADDR_FIXED    = 4'h7;
  localparam logic [3:0] BIT_LAST      = 4'h7;
  localparam logic [3:0] BIT_ACK       = 4'h8;
  localparam logic [3:0] BIT_ACK_DONE  = 4'h9;
  localparam logic [2:0] CR_TARGET     = 3'h0;
  localparam logic [2:0] CR_CMD        = 3'h1;
  localparam logic [2:0] CR_WDATA      = 3'h2;
  localparam logic [2:0] CR_GO         = 3'h3;
  localparam logic [2:0] CR_STATUS     = 3'h4;
  localparam logic [2:0] CR_RDATA      = 3'h5;
  localparam logic [6:0] RST_TARGET    = 7'h38;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CMD, ST_WDATA, ST_RDATA, ST_SKIP} gpx_tst_t;
  typedef enum logic [1:0] {A_START, A_TX, A_RX, A_STOP} gpx_act_t;
endpackage : gpx_pkg

/* File: include/gpx_if.sv */
// two-wire link plus interrupt line between controller and expander
`timescale 1ns/10ps
interface gpx_if;
  logic scl_o;
  logic scl_oe;
  logic c_sda_o;
  logic c_sda_oe;
  logic t_sda_o;
  logic t_sda_oe;
  logic t_int_o;
  logic t_int_oe;
  logic scl;
  logic sda;
  logic int_n;
  // wired-and of the open-drain drivers, pull-up when nobody drives
  assign scl   = ~(scl_oe & ~scl_o);
  assign sda   = ~((c_sda_oe & ~c_sda_o) | (t_sda_oe & ~t_sda_o));
  assign int_n = ~(t_int_oe & ~t_int_o);
  modport ctrl (output scl_o, output scl_oe, output c_sda_o, output c_sda_oe,
                input sda, input int_n);
  modport tgt  (output t_sda_o, output t_sda_oe, output t_int_o, output t_int_oe,
                input scl, input sda);
endinterface : gpx_if

/* File: rtl/gpx_target.sv */
// expander end: two-wire target, four registers, port pins, change interrupt
// What this block does
// - byte after acked address is command byte
// - command byte only taken in write transfers
// - register selection kept across transfers
// - codes 0..3 select level, latch, invert, direction
// - level register returns pin levels, any direction
// - writes to level register acked, ignored
// - latch drives pin only when direction output
// - latch reads back stored bits, resets ones
// - invert bit flips level bit, resets zero
// - direction one input, zero output, resets ones
// - write: start, address w, code, data, stop
// - selection fixed; last written byte remains
// - read: code write, restart, address r
// - repeated reads return same selected register
// - tx byte sampled at ack clock rise
// - controller nacks last wanted byte
// - stop anywhere; last byte with all eight data bits stands, acked or not
// - address is fixed upper bits plus straps
// - input pin edge asserts interrupt low
// - interrupt clears on restore or level read
`timescale 1ns/10ps
module gpx_target
  import gpx_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  gpx_if.tgt              bus,
  input  wire logic [2:0] address_strap_pins,
  input  wire logic [7:0] port_pins_i,
  output logic      [7:0] port_pins_o,
  output logic      [7:0] port_pins_oe
);

  logic [2:0] scl_s_r;
  logic [2:0] sda_s_r;
  logic [7:0] pin_s1_r;
  logic [7:0] pin_s2_r;
  logic [2:0] strap_s1_r;
  logic [2:0] strap_s2_r;
  gpx_tst_t   st_r;
  logic [3:0] bit_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic       sda_oe_r;
  logic [1:0] sel_r;
  logic [7:0] latch_r;
  logic [7:0] inv_r;
  logic [7:0] dir_r;
  logic [7:0] ref_r;
  logic       init_r;
  logic       int_r;

  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic [7:0] rx_byte;
  logic       tx_load;
  logic [7:0] pin_level;

  function automatic logic [7:0] rd_sel(input logic [1:0] sel, input logic [7:0] lvl,
                                        input logic [7:0] lat, input logic [7:0] inv,
                                        input logic [7:0] dir);
    case (sel)
      REG_PIN_LEVEL: rd_sel = lvl;
      REG_OUT_LATCH: rd_sel = lat;
      REG_INV_MASK:  rd_sel = inv;
      default:       rd_sel = dir;
    endcase
  endfunction : rd_sel

  // stage 0 is read only by stage 1; stage 2 gives the edge reference
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      scl_s_r    <= 3'h7;
      sda_s_r    <= 3'h7;
      strap_s1_r <= 3'h0;
      strap_s2_r <= 3'h0;
    end
    else
    begin
      scl_s_r    <= {scl_s_r[1:0], bus.scl};
      sda_s_r    <= {sda_s_r[1:0], bus.sda};
      strap_s1_r <= address_strap_pins;
      strap_s2_r <= strap_s1_r;
    end
  end

  // pin sync left unreset: the change reference must see real levels at release
  always_ff @(posedge clk_sys)
  begin
    pin_s1_r <= port_pins_i;
    pin_s2_r <= pin_s1_r;
  end

  assign scl_rise  = scl_s_r[1] & ~scl_s_r[2];
  assign scl_fall  = ~scl_s_r[1] & scl_s_r[2];
  assign start_c   = scl_s_r[1] & scl_s_r[2] & ~sda_s_r[1] & sda_s_r[2];
  assign stop_c    = scl_s_r[1] & scl_s_r[2] & sda_s_r[1] & ~sda_s_r[2];
  assign rx_byte   = {shift_r[6:0], sda_s_r[1]};
  assign pin_level = pin_s2_r ^ inv_r;
  // ack clock rise on which a fresh transmit byte is taken
  assign tx_load   = scl_rise && bit_r == BIT_ACK &&
                     ((st_r == ST_ADDR && shift_r[0]) || (st_r == ST_RDATA && !sda_s_r[1]));

  // transfer sequencing; start and stop override any bit position
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_r     <= ST_IDLE;
      bit_r    <= 4'h0;
      shift_r  <= 8'h00;
      tx_r     <= 8'h00;
      sda_oe_r <= 1'b0;
    end
    else if (start_c)
    begin
      st_r     <= ST_ADDR;
      bit_r    <= 4'h0;
      sda_oe_r <= 1'b0;
    end
    else if (stop_c)
    begin
      st_r     <= ST_IDLE;
      sda_oe_r <= 1'b0;
    end
    else if (scl_rise && st_r != ST_IDLE)
    begin
      if (bit_r < BIT_ACK)
      begin
        shift_r <= rx_byte;
        bit_r   <= bit_r + 4'h1;
        if (bit_r == BIT_LAST && st_r == ST_ADDR && rx_byte[7:1] != {ADDR_FIXED, strap_s2_r})
          st_r <= ST_SKIP;
      end
      else if (bit_r == BIT_ACK)
      begin
        bit_r <= BIT_ACK_DONE;
        case (st_r)
          ST_ADDR:  st_r <= shift_r[0] ? ST_RDATA : ST_CMD;
          ST_CMD:   st_r <= ST_WDATA;
          ST_RDATA: if (sda_s_r[1]) st_r <= ST_SKIP;
          default:  st_r <= st_r;
        endcase
        if (tx_load)
          tx_r <= rd_sel(sel_r, pin_level, latch_r, inv_r, dir_r);
      end
    end
    else if (scl_fall && st_r != ST_IDLE)
    begin
      if (bit_r == BIT_ACK)
        sda_oe_r <= (st_r == ST_ADDR || st_r == ST_CMD || st_r == ST_WDATA);
      else if (bit_r == BIT_ACK_DONE)
      begin
        bit_r    <= 4'h0;
        sda_oe_r <= (st_r == ST_RDATA) && !tx_r[7];
      end
      else if (st_r == ST_RDATA && bit_r != 4'h0)
        sda_oe_r <= !tx_r[3'(4'h7 - bit_r)];
      else
        sda_oe_r <= 1'b0;
    end
  end

  // register writes land at the last data bit; later bytes overwrite
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sel_r   <= RST_SEL;
      latch_r <= RST_OUT_LATCH;
      inv_r   <= RST_INV_MASK;
      dir_r   <= RST_PIN_DIR;
    end
    else if (scl_rise && bit_r == BIT_LAST && !start_c && !stop_c)
    begin
      if (st_r == ST_CMD)
        sel_r <= rx_byte[1:0];
      else if (st_r == ST_WDATA)
      begin
        case (sel_r)
          REG_OUT_LATCH: latch_r <= rx_byte;
          REG_INV_MASK:  inv_r   <= rx_byte;
          REG_PIN_DIR:   dir_r   <= rx_byte;
          default:       latch_r <= latch_r;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      port_pins_o  <= RST_OUT_LATCH;
      port_pins_oe <= 8'h00;
    end
    else
    begin
      port_pins_o  <= latch_r;
      port_pins_oe <= ~dir_r;
    end
  end

  // reference snapshot taken after reset release, so pin levels of the world
  // at power-up do not raise a spurious change
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ref_r  <= 8'h00;
      init_r <= 1'b0;
      int_r  <= 1'b0;
    end
    else
    begin
      init_r <= 1'b1;
      if (!init_r || (tx_load && sel_r == REG_PIN_LEVEL))
        ref_r <= pin_s2_r;
      int_r <= init_r && !(tx_load && sel_r == REG_PIN_LEVEL) &&
               (|((pin_s2_r ^ ref_r) & dir_r));
    end
  end

  assign bus.t_sda_o  = 1'b0;
  assign bus.t_sda_oe = sda_oe_r;
  assign bus.t_int_o  = 1'b0;
  assign bus.t_int_oe = int_r;

endmodule : gpx_target

/* File: sim/gpx_link_properties.sv */
// concurrent checks on the two-wire carrier between controller and expander
`timescale 1ns/10ps
module gpx_link_properties
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic c_sda_o,
  input wire logic c_sda_oe,
  input wire logic t_sda_o,
  input wire logic t_sda_oe,
  input wire logic t_int_o,
  input wire logic t_int_oe,
  input wire logic scl,
  input wire logic sda,
  input wire logic int_n
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  // open drain: nobody may ever drive a high level
  AST_OPEN_DRAIN: assert property (!(scl_o | c_sda_o | t_sda_o | t_int_o))
    else $error("a link driver put out a high level");
  AST_IDLE_AFTER_RESET: assert property ($fell(sys_rst) |-> scl && sda && int_n)
    else $error("link or interrupt not idle after reset");
  // target data may only move while the clock is low, else it fakes start or stop
  AST_TGT_SDA_SCL_LOW: assert property ($changed(t_sda_oe) |-> !scl)
    else $error("target moved sda while scl high");
  AST_START_BY_CTRL: assert property ($fell(sda) && scl |-> c_sda_oe)
    else $error("start condition not made by controller");
  AST_STOP_BY_CTRL: assert property ($rose(sda) && scl |-> !t_sda_oe && $past(c_sda_oe))
    else $error("stop condition not made by controller");
  AST_SCL_LOW_BOUND: assert property ($fell(scl) |-> ##[1:80] scl)
    else $error("scl held low too long");
  AST_SCL_HIGH_MIN: assert property ($rose(scl) |-> scl[*8])
    else $error("scl high pulse too short");
  AST_TGT_RELEASE: assert property ($rose(t_sda_oe) |-> ##[1:1000] !t_sda_oe)
    else $error("target kept sda low past one byte");
endmodule : gpx_link_properties

/* File: sim/i2c_gpio_expander_regs_tb.sv */
// self-checking bench: controller and expander joined over the two-wire carrier
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module i2c_gpio_expander_regs_tb;
  import gpx_pkg::*;
  localparam int LIMIT = 90000;
  logic       clk_sys = 1'b0;
  logic       sys_rst;
  logic [2:0] address_strap_pins;
  logic [7:0] port_pins_i;
  logic [7:0] port_pins_o;
  logic [7:0] port_pins_oe;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic [7:0] d;
  logic [7:0] rst_tab [4] = '{8'h00, 8'hFF, 8'h00, 8'hFF};
  int         mismatches = 0;
  int         compares = 0;
  int         cyc = 0;

  gpx_if bus_if();
  gpx_ctrl gpx_ctrl_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus(bus_if), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  gpx_target gpx_target_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus(bus_if),
    .address_strap_pins(address_strap_pins), .port_pins_i(port_pins_i),
    .port_pins_o(port_pins_o), .port_pins_oe(port_pins_oe));
  gpx_link_properties gpx_link_properties_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .scl_o(bus_if.scl_o), .scl_oe(bus_if.scl_oe), .c_sda_o(bus_if.c_sda_o),
    .c_sda_oe(bus_if.c_sda_oe), .t_sda_o(bus_if.t_sda_o), .t_sda_oe(bus_if.t_sda_oe),
    .t_int_o(bus_if.t_int_o), .t_int_oe(bus_if.t_int_oe), .scl(bus_if.scl),
    .sda(bus_if.sda), .int_n(bus_if.int_n));

  always #5 clk_sys = ~clk_sys;

  task automatic give_verdict();
    if (mismatches == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  // hang guard: ends the run at LIMIT cycles; busy polling itself gives up after 3000 reads
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic cwr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : cwr

  task automatic crd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : crd

  // start a sequence and poll busy; returns the last status seen
  task automatic xfer(input logic [7:0] go, output logic [7:0] st);
    int n;
    cwr(3'h3, go);
    n = 0;
    st = 8'h01;
    while (st[0] !== 1'b0 && n < 3000)
    begin
      crd(3'h4, st);
      n++;
    end
    `CHK("sequence finished", 1'b0, st[0])
  endtask : xfer

  task automatic regw(input logic [7:0] cmd, input logic [7:0] v, output logic [7:0] st);
    cwr(3'h1, cmd);
    cwr(3'h2, v);
    xfer(8'h00, st);
  endtask : regw

  task automatic regr(input logic [7:0] cmd, output logic [7:0] v);
    logic [7:0] st;
    cwr(3'h1, cmd);
    xfer(8'h01, st);
    crd(3'h5, v);
  endtask : regr

  // pins settle through the synchroniser before status is looked at
  task automatic pins(input logic [7:0] v, output logic [7:0] st);
    @(posedge clk_sys);
    port_pins_i <= v;
    repeat (10) @(posedge clk_sys);
    crd(3'h4, st);
  endtask : pins

  initial
  begin
    sys_rst            <= 1'b1;
    address_strap_pins <= 3'h0;
    port_pins_i        <= 8'hA5;
    reg_addr           <= 3'h0;
    reg_wdata          <= 8'h00;
    reg_wr             <= 1'b0;
    reg_rd             <= 1'b0;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1;
    `CHK("pin enables", 8'h00, port_pins_oe)
    `CHK("pin outputs", 8'hFF, port_pins_o)
    repeat (6) @(posedge clk_sys);
    crd(3'h4, d);
    `CHK("interrupt after reset", 1'b0, d[2])
    for (int k = 1; k < 4; k++)
    begin
      regr(8'(k), d);
      `CHK("reset value", rst_tab[k], d)
    end
    regr(8'h00, d);
    `CHK("pin levels", 8'hA5, d)
    regw(8'hF1, 8'h3C, d);
    regr(8'h01, d);
    `CHK("latch readback", 8'h3C, d)
    `CHK("pin outputs", 8'h3C, port_pins_o)
    regw(8'h03, 8'h0F, d);
    regr(8'h03, d);
    `CHK("direction", 8'h0F, d)
    `CHK("pin enables", 8'hF0, port_pins_oe)
    regw(8'h02, 8'hFF, d);
    regr(8'h00, d);
    `CHK("inverted levels", 8'h5A, d)
    regw(8'h02, 8'h00, d);
    regw(8'h00, 8'h00, d);
    regr(8'h00, d);
    `CHK("levels after write", 8'hA5, d)
    pins(8'h25, d);
    `CHK("interrupt from output pin", 1'b0, d[2])
    pins(8'h24, d);
    `CHK("interrupt on input edge", 1'b1, d[2])
    pins(8'h25, d);
    `CHK("interrupt after restore", 1'b0, d[2])
    pins(8'h27, d);
    `CHK("interrupt on input edge", 1'b1, d[2])
    regr(8'h00, d);
    `CHK("pin levels", 8'h27, d)
    crd(3'h4, d);
    `CHK("interrupt after level read", 1'b0, d[2])
    cwr(3'h0, 8'h39);
    crd(3'h0, d);
    `CHK("target setting", 8'h39, d)
    regw(8'h01, 8'h00, d);
    `CHK("nack on foreign address", 1'b1, d[1])
    @(posedge clk_sys);
    address_strap_pins <= 3'h1;
    repeat (5) @(posedge clk_sys);
    regr(8'h01, d);
    `CHK("latch untouched", 8'h3C, d)
    crd(3'h4, d);
    `CHK("ack on strapped address", 1'b0, d[1])
    give_verdict();
  end
endmodule : i2c_gpio_expander_regs_tb
